// ---- inc/rxs_consts.vh ----
`ifndef RXS_CONSTS_VH
`define RXS_CONSTS_VH

// pre-charge length in reference clock cycles
`define RXS_PRECHG_CYCLES   13'h1580
`define RXS_PRECHG_W        13

// auxiliary clock divider
`define RXS_CLKDIV_RATIO    8
`define RXS_CLKDIV_W        3

// synthesizer feedback chain, product always the total ratio
`define RXS_NTOT            24
`define RXS_DIV_W           4
`define RXS_N1_BAND_LOW     4'h4
`define RXS_N2_BAND_LOW     4'h6
`define RXS_N1_BAND_HIGH    4'h6
`define RXS_N2_BAND_HIGH    4'h4

// sequencer state codes, one-hot
`define RXS_ST_W            4
`define RXS_ST_SHUT         4'h1
`define RXS_ST_OSC_WAIT     4'h2
`define RXS_ST_PRECHG       4'h4
`define RXS_ST_ACTIVE       4'h8

`endif

// ---- design/rxs_div_chain.v ----
`timescale 1ns/1ps
`default_nettype none
`include "rxs_consts.vh"

module rxs_div_chain (
  input  wire                  clk,
  input  wire                  rstn,
  input  wire                  run,
  input  wire                  band,
  output reg                   lo2_pulse_q,
  output reg                   pfd_pulse_q,
  output wire [`RXS_DIV_W-1:0] n1_val,
  output wire [`RXS_DIV_W-1:0] n2_val
);

  reg  [`RXS_DIV_W-1:0] n1_cnt_q;
  reg  [`RXS_DIV_W-1:0] n2_cnt_q;
  wire                  n1_wrap;
  wire                  n2_wrap;

  // band sets the split between the two counters
  assign n1_val  = band ? `RXS_N1_BAND_HIGH : `RXS_N1_BAND_LOW;
  assign n2_val  = band ? `RXS_N2_BAND_HIGH : `RXS_N2_BAND_LOW;
  // >= rather than == so a band change mid-count cannot overrun
  assign n1_wrap = (n1_cnt_q >= n1_val - 4'h1);
  assign n2_wrap = (n2_cnt_q >= n2_val - 4'h1);

  // first counter output is the second local oscillator, the
  // second counter divides it further for the phase detector
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      n1_cnt_q    <= 4'h0;
      n2_cnt_q    <= 4'h0;
      lo2_pulse_q <= 1'b0;
      pfd_pulse_q <= 1'b0;
    end else if (!run) begin
      n1_cnt_q    <= 4'h0;
      n2_cnt_q    <= 4'h0;
      lo2_pulse_q <= 1'b0;
      pfd_pulse_q <= 1'b0;
    end else begin
      lo2_pulse_q <= n1_wrap;
      pfd_pulse_q <= n1_wrap && n2_wrap;
      if (n1_wrap) begin
        n1_cnt_q <= 4'h0;
        if (n2_wrap) begin
          n2_cnt_q <= 4'h0;
        end else begin
          n2_cnt_q <= n2_cnt_q + 4'h1;
        end
      end else begin
        n1_cnt_q <= n1_cnt_q + 4'h1;
      end
    end
  end

endmodule // rxs_div_chain
`default_nettype wire

// ---- design/rxs_startup_sequencer.v ----
// Notes on behaviour
// - receive-enable low keeps shutdown, every receive block off.
// - rising receive-enable edge starts bias and reference oscillator.
// - oscillator first; rest of receiver only after amplitude-reached indication.
// - amplitude-reached also starts capacitor pre-charge.
// - pre-charge ends after exactly 5504 counted clock cycles.
// - data output enabled only after pre-charge count completes.
// - auxiliary clock output is reference clock divided by 8.
// - feedback division from oscillator to phase detector totals 24.
// - two cascaded counters; first gives second LO, second feeds detector.
// - band select sets divider split and matching sideband.
// - modulation select routes FSK demodulator or OOK detector to filter.
// - amplifier select picks amplifiers; undriven in receive enables both.
// - undriven receive-enable reads low, leaving device in shutdown.
// - shutdown releases data output and filter/slicer pins to high-Z.
`timescale 1ns/1ps
`default_nettype none
`include "rxs_consts.vh"

module rxs_startup_sequencer #(
  parameter [`RXS_PRECHG_W-1:0] PRECHARGE_CYCLES = `RXS_PRECHG_CYCLES
) (
  // reference clock and reset
  input  wire                  CLK_SYS,
  input  wire                  RSTN,
  // host pins
  input  wire                  RX_ENABLE,
  input  wire                  BAND_SELECT,
  input  wire                  MOD_SELECT,
  input  wire                  AMP_SELECT,
  input  wire                  AMP_SELECT_HIZ,
  // analog status
  input  wire                  OSC_AMP_OK,
  input  wire                  SLICER_IN,
  // block enables
  output reg                   BIAS_EN,
  output reg                   OSC_EN,
  output reg                   RX_BLOCKS_EN,
  output reg                   PRECHARGE_EN,
  output reg                   FIRST_AMP_EN,
  output reg                   SECOND_AMP_EN,
  output reg                   FSK_DEMOD_EN,
  output reg                   OOK_DET_EN,
  output reg                   SIDEBAND_HIGH,
  // data output and data-path pins
  output reg                   DATA_OUT_O,
  output reg                   DATA_OUT_OE,
  output reg                   FILT_PINS_OE,
  // clock output, open drain
  output wire                  CLK_OUT_O,
  output reg                   CLK_OUT_OE,
  // synthesizer feedback chain
  output wire                  LO2_PULSE,
  output wire                  PFD_PULSE,
  output wire [`RXS_DIV_W-1:0] N1_VALUE,
  output wire [`RXS_DIV_W-1:0] N2_VALUE
);

  localparam [`RXS_ST_W-1:0] ST_SHUT     = `RXS_ST_SHUT;
  localparam [`RXS_ST_W-1:0] ST_OSC_WAIT = `RXS_ST_OSC_WAIT;
  localparam [`RXS_ST_W-1:0] ST_PRECHG   = `RXS_ST_PRECHG;
  localparam [`RXS_ST_W-1:0] ST_ACTIVE   = `RXS_ST_ACTIVE;

  reg  [`RXS_ST_W-1:0]     state_q;
  reg  [`RXS_ST_W-1:0]     state_d;
  reg                      enable_prev_q;
  reg  [`RXS_PRECHG_W-1:0] prechg_cnt_q;
  reg  [`RXS_PRECHG_W-1:0] prechg_cnt_d;
  reg  [`RXS_CLKDIV_W-1:0] clkdiv_q;
  wire                     enable_lvl;
  wire                     enable_rise;
  wire                     prechg_done;
  wire                     osc_running;
  wire                     rx_running;

  // an open or unknown pin reads as low, mimicking the pull-down
  assign enable_lvl  = (RX_ENABLE === 1'b1);
  assign enable_rise = enable_lvl && !enable_prev_q;
  assign prechg_done = (prechg_cnt_q == PRECHARGE_CYCLES - 13'h0001);

  // true in any state where the given block must be powered
  function in_any;
    input [`RXS_ST_W-1:0] st;
    input [`RXS_ST_W-1:0] set;
    begin
      in_any = |(st & set);
    end
  endfunction

  assign osc_running = in_any(state_q, ST_OSC_WAIT | ST_PRECHG | ST_ACTIVE);
  assign rx_running  = in_any(state_q, ST_PRECHG | ST_ACTIVE);

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      enable_prev_q <= 1'b0;
    end else begin
      enable_prev_q <= enable_lvl;
    end
  end

  // sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_SHUT: begin
        if (enable_rise) begin
          state_d = ST_OSC_WAIT;
        end
      end
      ST_OSC_WAIT: begin
        if (!enable_lvl) begin
          state_d = ST_SHUT;
        end else if (OSC_AMP_OK) begin
          state_d = ST_PRECHG;
        end
      end
      ST_PRECHG: begin
        if (!enable_lvl) begin
          state_d = ST_SHUT;
        end else if (prechg_done) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!enable_lvl) begin
          state_d = ST_SHUT;
        end
      end
      default: begin
        state_d = ST_SHUT;
      end
    endcase
  end

  // counter only runs in pre-charge, cleared everywhere else
  always @* begin
    prechg_cnt_d = {`RXS_PRECHG_W{1'b0}};
    if ((state_q == ST_PRECHG) && enable_lvl && !prechg_done) begin
      prechg_cnt_d = prechg_cnt_q + 13'h0001;
    end
  end

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_q      <= ST_SHUT;
      prechg_cnt_q <= {`RXS_PRECHG_W{1'b0}};
    end else begin
      state_q      <= state_d;
      prechg_cnt_q <= prechg_cnt_d;
    end
  end

  // block enables, all off in shutdown except SIDEBAND_HIGH, which follows BAND_SELECT in every state
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      BIAS_EN       <= 1'b0;
      OSC_EN        <= 1'b0;
      RX_BLOCKS_EN  <= 1'b0;
      PRECHARGE_EN  <= 1'b0;
      FIRST_AMP_EN  <= 1'b0;
      SECOND_AMP_EN <= 1'b0;
      FSK_DEMOD_EN  <= 1'b0;
      OOK_DET_EN    <= 1'b0;
      SIDEBAND_HIGH <= 1'b0;
    end else begin
      BIAS_EN       <= in_any(state_d, ST_OSC_WAIT | ST_PRECHG | ST_ACTIVE);
      OSC_EN        <= in_any(state_d, ST_OSC_WAIT | ST_PRECHG | ST_ACTIVE);
      RX_BLOCKS_EN  <= in_any(state_d, ST_PRECHG | ST_ACTIVE);
      PRECHARGE_EN  <= (state_d == ST_PRECHG);
      // floating select settles mid-supply: both amplifiers on
      FIRST_AMP_EN  <= in_any(state_d, ST_PRECHG | ST_ACTIVE)
                       && (AMP_SELECT_HIZ || !AMP_SELECT);
      SECOND_AMP_EN <= in_any(state_d, ST_PRECHG | ST_ACTIVE)
                       && (AMP_SELECT_HIZ || AMP_SELECT);
      FSK_DEMOD_EN  <= in_any(state_d, ST_PRECHG | ST_ACTIVE) && !MOD_SELECT;
      OOK_DET_EN    <= in_any(state_d, ST_PRECHG | ST_ACTIVE) && MOD_SELECT;
      SIDEBAND_HIGH <= BAND_SELECT;
    end
  end

  // data output and data-path pins
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      DATA_OUT_O   <= 1'b0;
      DATA_OUT_OE  <= 1'b0;
      FILT_PINS_OE <= 1'b0;
    end else begin
      DATA_OUT_O   <= (state_d == ST_ACTIVE) ? SLICER_IN : 1'b0;
      DATA_OUT_OE  <= (state_d == ST_ACTIVE);
      FILT_PINS_OE <= in_any(state_d, ST_PRECHG | ST_ACTIVE);
    end
  end

  // divide-by-8 clock; pin pulls low on the low half only
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      clkdiv_q   <= {`RXS_CLKDIV_W{1'b0}};
      CLK_OUT_OE <= 1'b0;
    end else if (!osc_running) begin
      clkdiv_q   <= {`RXS_CLKDIV_W{1'b0}};
      CLK_OUT_OE <= 1'b0;
    end else begin
      clkdiv_q   <= clkdiv_q + 3'h1;
      CLK_OUT_OE <= !clkdiv_q[`RXS_CLKDIV_W-1];
    end
  end

  assign CLK_OUT_O = 1'b0;

  // feedback divider only runs while the receiver is up
  rxs_div_chain u_div_chain (
    .clk         (CLK_SYS),
    .rstn        (RSTN),
    .run         (rx_running),
    .band        (BAND_SELECT),
    .lo2_pulse_q (LO2_PULSE),
    .pfd_pulse_q (PFD_PULSE),
    .n1_val      (N1_VALUE),
    .n2_val      (N2_VALUE)
  );

endmodule // rxs_startup_sequencer
`default_nettype wire

// ---- sim/rxs_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rxs_consts.vh"
module rxs_checker #(
  parameter [`RXS_PRECHG_W-1:0] PRECHARGE_CYCLES = `RXS_PRECHG_CYCLES
) (
  // pins and status
  input wire logic CLK_SYS, RSTN, RX_ENABLE, MOD_SELECT, AMP_SELECT, AMP_SELECT_HIZ,
  input wire logic OSC_AMP_OK, SLICER_IN, LO2_PULSE, PFD_PULSE,
  // enables and outputs
  input wire logic BIAS_EN, OSC_EN, RX_BLOCKS_EN, PRECHARGE_EN, FIRST_AMP_EN, SECOND_AMP_EN,
  input wire logic FSK_DEMOD_EN, OOK_DET_EN, DATA_OUT_O, DATA_OUT_OE, FILT_PINS_OE, CLK_OUT_OE,
  input wire logic [`RXS_DIV_W-1:0] N1_VALUE
);
  logic [`RXS_PRECHG_W-1:0] pre_q;
  logic [5:0]               pfd_gap_q, lo_gap_q;
  logic                     pfd_seen_q, lo_seen_q;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      pre_q <= '0;
      {pfd_gap_q, lo_gap_q, pfd_seen_q, lo_seen_q} <= 14'h0;
    end else begin
      pre_q      <= PRECHARGE_EN ? pre_q + 1'b1 : '0;
      pfd_gap_q  <= PFD_PULSE ? 6'h1 : pfd_gap_q + 6'h1;
      lo_gap_q   <= LO2_PULSE ? 6'h1 : lo_gap_q + 6'h1;
      // first pulse after start-up has no reference gap
      pfd_seen_q <= RX_BLOCKS_EN && (pfd_seen_q || PFD_PULSE);
      lo_seen_q  <= RX_BLOCKS_EN && (lo_seen_q || LO2_PULSE);
    end
  end
  sequence s_clock_div_stage;
    CLK_OUT_OE [*4] ##1 !CLK_OUT_OE [*4] ##1 CLK_OUT_OE;
  endsequence
  property p_clock_div_stage;
    disable iff (!RSTN || !RX_ENABLE) $rose(CLK_OUT_OE) |-> s_clock_div_stage;
  endproperty
  a_shut_quiet: assert property (
    !RX_ENABLE |=> !(OSC_EN || BIAS_EN || RX_BLOCKS_EN || DATA_OUT_OE || FILT_PINS_OE))
    else $error("receiver active after enable low");
  a_enable_start: assert property (RX_ENABLE && !$past(RX_ENABLE) |=> OSC_EN && BIAS_EN)
    else $error("enable edge did not start oscillator");
  a_osc_first: assert property (
    $rose(RX_BLOCKS_EN) |-> $rose(PRECHARGE_EN) && $past(OSC_EN) && $past(OSC_AMP_OK))
    else $error("receiver up without oscillator amplitude");
  a_prechg_len: assert property (
    $fell(PRECHARGE_EN) && $past(RX_ENABLE) |-> pre_q == PRECHARGE_CYCLES && DATA_OUT_OE)
    else $error("precharge length or data enable wrong");
  a_clk_div: assert property (p_clock_div_stage)
    else $error("clock output period not eight");
  a_pfd_ratio: assert property (PFD_PULSE && pfd_seen_q |-> pfd_gap_q == 6'h18)
    else $error("feedback ratio not 24");
  a_lo2_ratio: assert property (LO2_PULSE && lo_seen_q |-> lo_gap_q == {2'h0, N1_VALUE})
    else $error("second lo period differs from first divider");
  a_mod_route: assert property (
    RX_BLOCKS_EN && $stable(MOD_SELECT) |-> FSK_DEMOD_EN == !MOD_SELECT && OOK_DET_EN == MOD_SELECT)
    else $error("demodulator routing wrong");
  a_amp_pick: assert property (RX_BLOCKS_EN && $stable({AMP_SELECT, AMP_SELECT_HIZ}) |->
    FIRST_AMP_EN == (AMP_SELECT_HIZ || !AMP_SELECT) && SECOND_AMP_EN == (AMP_SELECT_HIZ || AMP_SELECT))
    else $error("amplifier selection wrong");
  a_data_follow: assert property (
    DATA_OUT_OE && $past(DATA_OUT_OE) |-> DATA_OUT_O == $past(SLICER_IN))
    else $error("data output does not follow slicer");
endmodule // rxs_checker
bind rxs_startup_sequencer rxs_checker #(.PRECHARGE_CYCLES(PRECHARGE_CYCLES)) u_chk (.*);
`default_nettype wire

// ---- sim/rxs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rxs_host_model (
  input  wire logic       CLK_SYS, RSTN, OSC_EN, req, flt,
  input  wire logic [3:0] cfg,
  input  wire logic [7:0] dly,
  output wire logic       RX_ENABLE,
  output logic            BAND_SELECT, MOD_SELECT, AMP_SELECT, AMP_SELECT_HIZ,
  output logic            OSC_AMP_OK, SLICER_IN
);
  logic       en_q;
  logic [7:0] cnt_q;
  // undriven pin is z, the pull-down sits inside the device
  assign RX_ENABLE = flt ? 1'bz : en_q;
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      {en_q, BAND_SELECT, MOD_SELECT, AMP_SELECT, AMP_SELECT_HIZ} <= 5'h0;
      {OSC_AMP_OK, SLICER_IN, cnt_q} <= 10'h0;
    end else begin
      {BAND_SELECT, MOD_SELECT, AMP_SELECT, AMP_SELECT_HIZ} <= cfg;
      // selects settle a cycle ahead of the enable edge
      en_q       <= req && {BAND_SELECT, MOD_SELECT, AMP_SELECT, AMP_SELECT_HIZ} == cfg;
      cnt_q      <= OSC_EN ? cnt_q + {7'h0, cnt_q != dly} : 8'h0;
      OSC_AMP_OK <= OSC_EN && cnt_q == dly;
      SLICER_IN  <= ~SLICER_IN;
    end
  end
endmodule // rxs_host_model
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rxs_consts.vh"
module tb_top;
  localparam logic [12:0] PCYC = 13'h0008;
  logic CLK_SYS, RSTN, req, flt, oe_q;
  logic [3:0] cfg;
  logic [7:0] dly;
  wire RX_ENABLE, BAND_SELECT, MOD_SELECT, AMP_SELECT, AMP_SELECT_HIZ, OSC_AMP_OK, SLICER_IN;
  wire BIAS_EN, OSC_EN, RX_BLOCKS_EN, PRECHARGE_EN, FIRST_AMP_EN, SECOND_AMP_EN, FSK_DEMOD_EN;
  wire OOK_DET_EN, SIDEBAND_HIGH, DATA_OUT_O, DATA_OUT_OE, FILT_PINS_OE, CLK_OUT_O, CLK_OUT_OE;
  wire LO2_PULSE, PFD_PULSE;
  wire [`RXS_DIV_W-1:0] N1_VALUE, N2_VALUE;
  int fails, check_count, pc;
  logic [31:0] seed = 32'h941bcd0b;
  logic [12:0] expq[$];
  rxs_startup_sequencer #(.PRECHARGE_CYCLES(PCYC)) u_dut (.*);
  rxs_host_model u_host (.*);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(string nm, logic [12:0] exp, logic [12:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_hi(bit oe);
    for (int i = 0; i < 400; i++) begin
      @(negedge CLK_SYS);
      if ((oe ? DATA_OUT_OE : PRECHARGE_EN) === 1'b1)
        return;
    end
    fails++;
    summarize();
  endtask
  // scoreboard: precharge length measured at each data enable
  always @(posedge CLK_SYS) begin
    oe_q <= DATA_OUT_OE;
    pc   <= PRECHARGE_EN === 1'b1 ? pc + 1 : 0;
    if (DATA_OUT_OE === 1'b1 && oe_q !== 1'b1)
      check("precharge_len", expq.size() ? expq.pop_front() : 13'h1fff, pc[12:0]);
  end
  task automatic run(logic [3:0] c, int mode);
    logic [31:0] r;
    r = rnd();
    @(posedge CLK_SYS);
    cfg <= c;
    dly <= mode == 2 ? 8'hc8 : r[7:0] & 8'h0f;
    req <= 1'b1;
    if (mode == 0)
      expq.push_back(PCYC);
    if (mode == 2) begin
      repeat (6) @(negedge CLK_SYS);
      check("osc_first", 13'h6, {BIAS_EN, OSC_EN, RX_BLOCKS_EN});
    end else
      wait_hi(mode == 0);
    if (mode == 0) begin
      check("div_total", 13'h18, N1_VALUE * N2_VALUE);
      check("div_n1", c[3] ? `RXS_N1_BAND_HIGH : `RXS_N1_BAND_LOW, N1_VALUE);
      check("path_en", {~c[2], c[2], c[3]}, {FSK_DEMOD_EN, OOK_DET_EN, SIDEBAND_HIGH});
      check("amp_en", {c[0] | ~c[1], c[0] | c[1]}, {FIRST_AMP_EN, SECOND_AMP_EN});
      repeat (60) @(negedge CLK_SYS);
    end
    @(posedge CLK_SYS);
    req <= 1'b0;
    repeat (3) @(negedge CLK_SYS);
    check("shutdown", 0, {OSC_EN, RX_BLOCKS_EN, PRECHARGE_EN, DATA_OUT_OE, FILT_PINS_OE});
    $display("test cfg %0h mode %0d done", c, mode);
  endtask
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    {RSTN, req, flt, cfg, dly} = 15'h3000;
    repeat (5) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    req  <= 1'b1;
    repeat (10) @(negedge CLK_SYS);
    check("float_en", 0, {OSC_EN, DATA_OUT_OE, FILT_PINS_OE, CLK_OUT_O});
    @(posedge CLK_SYS);
    req <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    flt <= 1'b0;
    for (int i = 0; i < 16; i++)
      run(i[3:0], 0);
    run(4'h5, 1);
    run(4'ha, 2);
    run(4'h3, 0);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
